// ==== core/trx_top.sv ====
/*
 * trx_top: APB register file, halt tracking, anticollision termination,
 * slot selection, length filtering and response timing for target mode.
 * Assumes a synchronous receive front end, a protocol state machine that
 * reports select, polling and halt events, and one clock, pclk.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module trx_top
	import trx_pkg::*;
(
	input wire logic pclk, // 20 MHz block clock
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire trx_pkg::trx_rate_t rx_rate, // current bit rate
	input wire logic card_mode, // card operation mode
	input wire logic passive_mode, // passive communication
	input wire logic sync_detect_en, // sync detect from mode reg
	input wire logic rf_reset, // rf reset, pulse
	input wire trx_pkg::trx_rx_t rx, // received bytes
	input wire logic bit_tick, // data bit period, pulse
	input wire logic halt_cmd_seen, // state machine halts card
	input wire logic auto_anticollision_cmd_active, // auto anticollision runs
	input wire logic select_done, // type a select completed
	input wire logic polling_done, // polling completed
	input wire logic valid_cmd, // valid command received
	input wire logic tx_req, // transmit wanted, level
	input wire logic bit_sync_ok, // tx bit phase aligned
	output logic auto_anticollision_cmd_end, // end anticollision, pulse
	output logic active_mode_allow, // active mode permitted
	output logic slot_half, // half length time slot
	output logic [2:0] decoder_sensitivity, // miller sensitivity
	output logic [1:0] decoder_time_const, // miller time constant
	output logic pkt_accept, // packet delivered, pulse
	output logic pkt_discard, // packet dropped, pulse
	output logic tx_start, // transmission begins, pulse
	output logic tx_holding // request waits on timing
);

	////////////////////////////////////////////////////////////////////
	// apb decode

	trx_lim_t lim_q;
	trx_lim_t lim_d;
	trx_card_t card_q;
	trx_card_t card_d;
	logic halted_q;
	logic halted_d;
	logic selected_q;
	logic selected_d;
	logic auto_anticollision_cmd_end_q;
	logic slot_half_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic resp_elapsed;
	logic drop_seen_q;

	// decode that the read mux and the write path share
	function automatic logic [2:0] reg_hit(input logic [7:0] addr);
		reg_hit = {addr == (IDX_STATUS << ADDR_SHIFT),
			addr == (IDX_CARD << ADDR_SHIFT),
			addr == (IDX_LIMITS << ADDR_SHIFT)};
	endfunction : reg_hit

	logic setup;
	logic access;
	logic wr;
	logic [2:0] hit;
	logic mapped;
	logic wr_lim;
	logic wr_card;
	logic [7:0] status;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit = reg_hit(paddr);
	assign mapped = |hit;
	// a write lands only with the low byte lane strobed
	assign wr = access && pwrite && pstrb[0] && mapped;
	assign wr_lim = wr && hit[0];
	assign wr_card = wr && hit[1];
	// zero wait state: every access ends in its first access cycle
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////
	// registers

	assign lim_d = wr_lim ? trx_lim_t'(pwdata[7:0]) : lim_q;

	// host write and hardware may both set; rf reset always clears
	assign halted_d = rf_reset ? 1'b0 :
		(halt_cmd_seen ? 1'b1 :
		(wr_card ? pwdata[CARD_HALT_BIT] : halted_q));

	always_comb begin
		card_d = card_q;
		if (wr_card) begin
			card_d = trx_card_t'(pwdata[7:0]);
		end
		card_d.card_halted_flag = halted_d;
	end

	// configuration storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_q <= trx_lim_t'(LIMITS_RST);
			card_q <= trx_card_t'(CARD_RST);
		end else begin
			lim_q <= lim_d;
			card_q <= card_d;
		end
	end

	assign halted_q = card_q.card_halted_flag;

	////////////////////////////////////////////////////////////////////
	// read path, registered in the setup cycle

	assign status = {4'h0, drop_seen_q, selected_q, tx_holding, resp_elapsed};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= hit[0] ? {24'h0000_00, lim_q} :
				hit[1] ? {24'h0000_00, card_q} :
				hit[2] ? {24'h0000_00, status} : '0;
			pslverr_q <= !mapped;
		end
	end

	assign prdata = prdata_q;
	// error only shows while the access phase is on the bus
	assign pslverr = access && pslverr_q;

	////////////////////////////////////////////////////////////////////
	// anticollision termination

	logic sel_event;
	logic term_now;

	assign sel_event = select_done || polling_done;
	// selection is remembered only while the command runs
	assign selected_d = (rf_reset || !auto_anticollision_cmd_active || term_now) ? 1'b0 :
		(selected_q || sel_event);
	assign term_now = auto_anticollision_cmd_active && valid_cmd &&
		(!lim_q.hold_until_selected || selected_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			selected_q <= 1'b0;
			auto_anticollision_cmd_end_q <= 1'b0;
		end else begin
			selected_q <= selected_d;
			auto_anticollision_cmd_end_q <= term_now;
		end
	end

	assign auto_anticollision_cmd_end = auto_anticollision_cmd_end_q;
	assign active_mode_allow = !lim_q.hold_until_selected;

	////////////////////////////////////////////////////////////////////
	// slot length and decoder settings

	// half slot applies only in passive mode at 424 kbit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot_half_q <= 1'b0;
		end else begin
			slot_half_q <= passive_mode && (rx_rate == RATE_424) &&
				lim_q.half_slot_sel;
		end
	end

	assign slot_half = slot_half_q;
	assign decoder_sensitivity = card_q.decoder_sensitivity;
	assign decoder_time_const = card_q.decoder_time_const;

	////////////////////////////////////////////////////////////////////
	// length filter and response timer

	logic check_en;
	logic halt_filter;

	assign check_en = !((rx_rate == RATE_106) && !sync_detect_en);
	assign halt_filter = halted_q && card_mode && (rx_rate == RATE_106);

	trx_len_filter trx_len_filter_i (
		.pclk(pclk),
		.presetn(presetn),
		.rx(rx),
		.check_en(check_en),
		.max_field(lim_q.max_len_quads),
		.halt_filter(halt_filter),
		.accept(pkt_accept),
		.discard(pkt_discard)
	);

	trx_resp_timer trx_resp_timer_i (
		.pclk(pclk),
		.presetn(presetn),
		.frame_end(rx.frame_end),
		.bit_tick(bit_tick),
		.wait_extra(card_q.response_wait_extra),
		.tx_req(tx_req),
		.bit_sync_ok(bit_sync_ok),
		.elapsed(resp_elapsed),
		.tx_start(tx_start)
	);

	assign tx_holding = tx_req && !resp_elapsed;

	// note for software that a packet was thrown away, held until the next frame end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drop_seen_q <= 1'b0;
		end else begin
			drop_seen_q <= pkt_discard || (drop_seen_q && !rx.frame_end);
		end
	end

	////////////////////////////////////////////////////////////////////
	// assertions

	// helper: data bits since the last frame end, saturating
	logic [3:0] bits_seen_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bits_seen_q <= 4'hf;
		end else if (rx.frame_end) begin
			bits_seen_q <= '0;
		end else if (bit_tick && bits_seen_q != 4'hf) begin
			bits_seen_q <= bits_seen_q + 4'h1;
		end
	end

	property p_no_early_tx;
		@(posedge pclk) disable iff (!presetn)
		tx_start |-> $past(bits_seen_q) >= RESP_BASE_BITS + {2'b00, card_q.response_wait_extra};
	endproperty
	a_no_early_tx: assert property (p_no_early_tx)
		else $error("transmit started before minimum response time");

	property p_hold_early;
		@(posedge pclk) disable iff (!presetn)
		(rx.frame_end ##1 tx_req) |-> !tx_start [*3];
	endproperty
	a_hold_early: assert property (p_hold_early)
		else $error("transmit not held after frame end");

	property p_start_late;
		@(posedge pclk) disable iff (!presetn)
		(resp_elapsed && $rose(tx_req && bit_sync_ok) && !rx.frame_end) |=> tx_start;
	endproperty
	a_start_late: assert property (p_start_late)
		else $error("late transmit did not start at once");

	property p_rf_clear;
		@(posedge pclk) disable iff (!presetn)
		rf_reset |=> !card_q.card_halted_flag;
	endproperty
	a_rf_clear: assert property (p_rf_clear)
		else $error("halt flag survived rf reset");

	property p_hw_halt;
		@(posedge pclk) disable iff (!presetn)
		(halt_cmd_seen && !rf_reset) |=> card_q.card_halted_flag;
	endproperty
	a_hw_halt: assert property (p_hw_halt)
		else $error("state machine halt not recorded");

	property p_term_needs_sel;
		@(posedge pclk) disable iff (!presetn)
		(auto_anticollision_cmd_end && $past(lim_q.hold_until_selected)) |->
		$past(selected_q);
	endproperty
	a_term_needs_sel: assert property (p_term_needs_sel)
		else $error("anticollision ended without selection");

	property p_no_active;
		@(posedge pclk) disable iff (!presetn)
		lim_q.hold_until_selected |-> !active_mode_allow;
	endproperty
	a_no_active: assert property (p_no_active)
		else $error("active mode allowed while waiting for selection");

	property p_slot;
		@(posedge pclk) disable iff (!presetn)
		##1 slot_half == $past(passive_mode && rx_rate == RATE_424 &&
		lim_q.half_slot_sel);
	endproperty
	a_slot: assert property (p_slot)
		else $error("slot length selection wrong");

	property p_verdict_once;
		@(posedge pclk) disable iff (!presetn)
		rx.frame_end |=> (pkt_accept ^ pkt_discard);
	endproperty
	a_verdict_once: assert property (p_verdict_once)
		else $error("frame end without exactly one verdict");

	property p_no_check_106;
		@(posedge pclk) disable iff (!presetn)
		(rx.frame_end && rx_rate == RATE_106 && !sync_detect_en &&
		!halt_filter) |=> pkt_accept;
	endproperty
	a_no_check_106: assert property (p_no_check_106)
		else $error("length checked at 106 kbit without sync detect");

	property p_decoder;
		@(posedge pclk) disable iff (!presetn)
		wr_card |=> decoder_sensitivity == $past(pwdata[7:5]) &&
		decoder_time_const == $past(pwdata[4:3]);
	endproperty
	a_decoder: assert property (p_decoder)
		else $error("decoder settings not taken from write");

	c_discard: cover property (@(posedge pclk) disable iff (!presetn) pkt_discard);
	c_hold: cover property (@(posedge pclk) disable iff (!presetn)
		tx_holding ##[1:40] tx_start);
	c_term_sel: cover property (@(posedge pclk) disable iff (!presetn)
		auto_anticollision_cmd_end && lim_q.hold_until_selected);
	c_halt_rf: cover property (@(posedge pclk) disable iff (!presetn)
		halted_q ##1 rf_reset);

endmodule : trx_top

// ==== core/trx_pkg.sv ====
/*
 * trx_pkg: register indices, reset values, field layouts and
 * shared types for the target receive length and response-timing block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package trx_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LIMITS = 8'h1b;
	localparam logic [7:0] IDX_CARD = 8'h1c;
	localparam logic [7:0] IDX_STATUS = 8'h20;
	localparam int ADDR_SHIFT = 2;

	// reset values
	localparam logic [7:0] LIMITS_RST = 8'h00;
	localparam logic [7:0] CARD_RST = 8'h62;

	// field positions
	localparam int CARD_HALT_BIT = 2;

	// length check: field value times four, zero means the largest packet
	localparam int LEN_W = 10;
	localparam int QUAD_SHIFT = 2;
	localparam logic [LEN_W-1:0] ZERO_LEN_BYTES = 10'h100;

	// response time base in data bits
	localparam logic [3:0] RESP_BASE_BITS = 4'h7;

	// the only request code honoured while halted in card mode at 106 kbit
	localparam logic [7:0] REQ_HALTED_CODE = 8'h52;

	// receive bit rate
	typedef enum logic [1:0] {
		RATE_106,
		RATE_212,
		RATE_424
	} trx_rate_t;

	// frame limits register layout
	typedef struct packed {
		logic hold_until_selected;
		logic half_slot_sel;
		logic [5:0] max_len_quads;
	} trx_lim_t;

	// card mode decoder and timing register layout
	typedef struct packed {
		logic [2:0] decoder_sensitivity;
		logic [1:0] decoder_time_const;
		logic card_halted_flag;
		logic [1:0] response_wait_extra;
	} trx_card_t;

	// one received byte or the end of a frame
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic frame_end;
		logic is_request;
	} trx_rx_t;

endpackage : trx_pkg

// ==== core/trx_len_filter.sv ====
/*
 * trx_len_filter: counts the bytes of a received packet and gives an
 * accept or discard verdict at the end of the frame.
 * Assumes frame_end comes in a cycle of its own after the last byte.
 */
`timescale 1ns/100ps
module trx_len_filter
	import trx_pkg::*;
#(
	parameter int CNT_W = trx_pkg::LEN_W
) (
	input wire logic pclk, // block clock
	input wire logic presetn, // async reset, active low
	input wire trx_pkg::trx_rx_t rx, // received byte stream
	input wire logic check_en, // apply the maximum length
	input wire logic [5:0] max_field, // maximum length in quads
	input wire logic halt_filter, // halted, card mode, 106 kbit
	output logic accept, // packet delivered, pulse
	output logic discard // packet dropped, pulse
);
	logic [CNT_W-1:0] cnt_q;
	logic first_q;
	logic bad_q;
	logic accept_q;
	logic discard_q;
	logic [CNT_W-1:0] limit;
	logic over;
	logic req_bad;
	logic [CNT_W-1:0] cnt_inc;

	// zero stands for the largest packet
	assign limit = (max_field == '0) ? CNT_W'(ZERO_LEN_BYTES) :
		CNT_W'({max_field, {QUAD_SHIFT{1'b0}}});
	assign over = check_en && (cnt_q > limit);
	// saturate so a huge packet cannot wrap back under the limit
	assign cnt_inc = (&cnt_q) ? cnt_q : cnt_q + CNT_W'(1);
	assign req_bad = rx.valid && first_q && rx.is_request && halt_filter &&
		(rx.data != REQ_HALTED_CODE);

	// byte counting, cleared at each frame end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			first_q <= 1'b1;
			bad_q <= 1'b0;
		end else if (rx.frame_end) begin
			cnt_q <= '0;
			first_q <= 1'b1;
			bad_q <= 1'b0;
		end else if (rx.valid) begin
			cnt_q <= cnt_inc;
			first_q <= 1'b0;
			bad_q <= bad_q | req_bad;
		end
	end

	// verdict at the end of the frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_q <= 1'b0;
			discard_q <= 1'b0;
		end else begin
			accept_q <= rx.frame_end && !(over || bad_q);
			discard_q <= rx.frame_end && (over || bad_q);
		end
	end

	assign accept = accept_q;
	assign discard = discard_q;

endmodule : trx_len_filter

// ==== core/trx_resp_timer.sv ====
/*
 * trx_resp_timer: counts data bits from the end of a received frame and
 * holds a transmit request until the minimum response time is over.
 * Assumes bit_tick pulses once per data bit of the current receive rate.
 */
`timescale 1ns/100ps
module trx_resp_timer
	import trx_pkg::*;
(
	input wire logic pclk, // block clock
	input wire logic presetn, // async reset, active low
	input wire logic frame_end, // end of last received bit, pulse
	input wire logic bit_tick, // one data bit period, pulse
	input wire logic [1:0] wait_extra, // extra response bits
	input wire logic tx_req, // transmit wanted, level
	input wire logic bit_sync_ok, // transmit bit phase aligned
	output logic elapsed, // minimum response time over
	output logic tx_start // transmission begins, pulse
);
	logic [3:0] cnt_q;
	logic elapsed_q;
	logic start_q;
	logic taken_q;
	logic [3:0] target;
	logic [3:0] cnt_inc;
	logic go;

	assign target = RESP_BASE_BITS + {2'b00, wait_extra};
	assign cnt_inc = cnt_q + 4'h1;
	assign go = tx_req && !taken_q && elapsed_q && bit_sync_ok;

	// bit counter started by the frame end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			elapsed_q <= 1'b1;
		end else if (frame_end) begin
			cnt_q <= '0;
			elapsed_q <= 1'b0;
		end else if (bit_tick && !elapsed_q) begin
			cnt_q <= cnt_inc;
			elapsed_q <= (cnt_inc >= target);
		end
	end

	// one start per request; the request must drop before the next
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
			taken_q <= 1'b0;
		end else begin
			start_q <= go;
			taken_q <= tx_req && (taken_q || go);
		end
	end

	assign elapsed = elapsed_q;
	assign tx_start = start_q;

endmodule : trx_resp_timer

// ==== tb/trx_reader_model.sv ====
/*
 * trx_reader_model: the reader on the far side; sends byte frames and
 * the data bit tick. Assumes the bench calls send_frame from its thread.
 */
`timescale 1ns/100ps
module trx_reader_model
	import trx_pkg::*;
(
	input wire logic pclk, // block clock
	output trx_pkg::trx_rx_t rx, // received byte stream
	output logic bit_tick // data bit period, pulse
);
	import trx_pkg::*;
	logic [1:0] div_q = 2'h0;
	////////////////////////////////////////
	// bit period of four clocks, restarted at the end of each frame so the
	// response time is measured from the last bit, not from a free phase
	assign bit_tick = (div_q == 2'h3) && !rx.frame_end;
	always_ff @(posedge pclk) begin
		div_q <= rx.frame_end ? 2'h0 : div_q + 2'h1;
	end
	initial rx = '0;
	////////////////////////////////////////
	// bytes back to back, end marker in a cycle of its own; idle data is
	// inverted so a stale byte is never mistaken for a fresh one
	task automatic send_frame(input int n, input logic [7:0] f, input logic req);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			rx <= '{1'b1, (i == 0) ? f : 8'(i), 1'b0, req && (i == 0)};
		end
		@(posedge pclk);
		rx <= '{1'b0, ~rx.data, 1'b1, 1'b0};
		@(posedge pclk);
		rx <= '{1'b0, ~rx.data, 1'b0, 1'b0};
	endtask : send_frame
endmodule : trx_reader_model

// ==== tb/trx_top_tb.sv ====
/*
 * trx_top_tb: self-checking bench for trx_top; registers over apb,
 * frames from the reader model. Assumes assertions sit in the design.
 */
`timescale 1ns/100ps
module trx_top_tb;
	import trx_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	trx_rate_t rx_rate;
	trx_rx_t rx;
	logic card_mode, passive_mode, sync_detect_en, rf_reset, bit_tick, halt_cmd_seen;
	logic auto_anticollision_cmd_active, select_done, polling_done, valid_cmd, tx_req, bit_sync_ok;
	logic auto_anticollision_cmd_end, active_mode_allow, slot_half, pkt_accept, pkt_discard;
	logic tx_start, tx_holding;
	logic [2:0] decoder_sensitivity;
	logic [1:0] decoder_time_const;
	int failures = 0;
	int n_tests = 0;
	localparam logic [7:0] A_LIM = IDX_LIMITS << ADDR_SHIFT;
	localparam logic [7:0] A_CARD = IDX_CARD << ADDR_SHIFT;
	localparam int P_RF = 0, P_HALT = 1, P_CMD = 2, P_SEL = 3, P_POLL = 4;

	trx_top trx_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr, .rx_rate, .card_mode, .passive_mode, .sync_detect_en,
		.rf_reset, .rx, .bit_tick, .halt_cmd_seen, .auto_anticollision_cmd_active, .select_done,
		.polling_done, .valid_cmd, .tx_req, .bit_sync_ok, .auto_anticollision_cmd_end, .active_mode_allow,
		.slot_half, .decoder_sensitivity, .decoder_time_const, .pkt_accept, .pkt_discard,
		.tx_start, .tx_holding);
	trx_reader_model trx_reader_model_i (.pclk, .rx, .bit_tick);

	////////////////////////////////////////
	// 20 MHz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	////////////////////////////////////////
	// reporting
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		failures++;
		end_of_test();
	endtask : hang

	////////////////////////////////////////
	// drivers; every wait is bounded so a dead handshake ends the run
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one-cycle pulse on the pin picked by k; a code, not a reference, so
	// every pin is still written by non-blocking assignment from here
	task automatic pulse(input int k);
		for (int v = 1; v >= 0; v--) begin
			@(posedge pclk);
			case (k)
				P_RF: rf_reset <= v[0];
				P_HALT: halt_cmd_seen <= v[0];
				P_CMD: valid_cmd <= v[0];
				P_SEL: select_done <= v[0];
				default: polling_done <= v[0];
			endcase
		end
	endtask : pulse
	task automatic within3(ref logic s, input logic e);
		logic seen;
		seen = 1'b0;
		repeat (3) begin
			@(negedge pclk);
			seen = seen | (s === 1'b1);
		end
		chk(seen, e);
		@(posedge pclk);
	endtask : within3
	task automatic frame(input int n, input logic [7:0] f, input logic q, input logic [1:0] e);
		trx_reader_model_i.send_frame(n, f, q);
		// the verdict stands only in the cycle after the frame end
		@(negedge pclk);
		chk({pkt_accept, pkt_discard}, e);
		@(posedge pclk);
	endtask : frame

	////////////////////////////////////////
	// scenarios
	task automatic t_regs();
		apb(1'b0, A_LIM, 32'h0);
		chk(rd, LIMITS_RST);
		apb(1'b0, A_CARD, 32'h0);
		chk(rd, CARD_RST);
		chk({decoder_sensitivity, decoder_time_const}, 5'h0c);
		apb(1'b1, A_CARD, 32'h0000_00b5);
		apb(1'b0, A_CARD, 32'h0);
		chk(rd, 32'h0000_00b5);
		chk({decoder_sensitivity, decoder_time_const}, 5'h16);
		pulse(P_RF);
		apb(1'b0, A_CARD, 32'h0);
		chk(rd, 32'h0000_00b1);
		// a write without the low byte lane must leave the register alone
		pstrb <= 4'he;
		apb(1'b1, A_CARD, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, A_CARD, 32'h0);
		chk(rd, 32'h0000_00b1);
		apb(1'b0, 8'h04, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic t_len();
		apb(1'b1, A_LIM, 32'h0000_0002);
		frame(8, 8'h11, 1'b0, 2'b10);
		frame(9, 8'h11, 1'b0, 2'b01);
		rx_rate <= RATE_106;
		frame(9, 8'h11, 1'b0, 2'b01);
		sync_detect_en <= 1'b0;
		frame(9, 8'h11, 1'b0, 2'b10);
		sync_detect_en <= 1'b1;
		rx_rate <= RATE_212;
		apb(1'b1, A_LIM, 32'h0);
		frame(256, 8'h11, 1'b0, 2'b10);
		frame(257, 8'h11, 1'b0, 2'b01);
		$display("test length done");
	endtask : t_len
	task automatic t_halt();
		card_mode <= 1'b1;
		rx_rate <= RATE_106;
		apb(1'b1, A_CARD, 32'h0000_0064);
		frame(2, 8'h26, 1'b1, 2'b01);
		frame(2, 8'h52, 1'b1, 2'b10);
		pulse(P_RF);
		frame(2, 8'h26, 1'b1, 2'b10);
		pulse(P_HALT);
		apb(1'b0, A_CARD, 32'h0);
		chk(rd, 32'h0000_0064);
		frame(2, 8'h26, 1'b1, 2'b01);
		pulse(P_RF);
		card_mode <= 1'b0;
		rx_rate <= RATE_212;
		$display("test halt done");
	endtask : t_halt
	task automatic t_resp();
		int i;
		int n;
		for (int w = 0; w < 4; w++) begin
			apb(1'b1, A_CARD, 32'h0000_0060 | w);
			trx_reader_model_i.send_frame(1, 8'h33, 1'b0);
			tx_req <= 1'b1;
			n = 0;
			for (i = 0; i < 100; i++) begin
				@(negedge pclk);
				if (tx_start === 1'b1) break;
				if (i == 2) chk(tx_holding, 1'b1);
				if (bit_tick === 1'b1) n++;
			end
			if (i == 100) hang();
			chk(n, RESP_BASE_BITS + w);
			@(posedge pclk);
			tx_req <= 1'b0;
		end
		// late request: only the bit phase may hold it back
		@(posedge pclk);
		bit_sync_ok <= 1'b0;
		tx_req <= 1'b1;
		repeat (6) @(negedge pclk);
		chk({tx_start, tx_holding}, 2'b00);
		@(posedge pclk);
		bit_sync_ok <= 1'b1;
		within3(tx_start, 1'b1);
		tx_req <= 1'b0;
		$display("test response done");
	endtask : t_resp
	task automatic t_acoll();
		apb(1'b1, A_LIM, 32'h0000_0080);
		@(negedge pclk);
		chk(active_mode_allow, 1'b0);
		@(posedge pclk);
		auto_anticollision_cmd_active <= 1'b1;
		pulse(P_CMD);
		within3(auto_anticollision_cmd_end, 1'b0);
		pulse(P_SEL);
		pulse(P_CMD);
		within3(auto_anticollision_cmd_end, 1'b1);
		auto_anticollision_cmd_active <= 1'b0;
		@(posedge pclk);
		auto_anticollision_cmd_active <= 1'b1;
		pulse(P_POLL);
		pulse(P_CMD);
		within3(auto_anticollision_cmd_end, 1'b1);
		auto_anticollision_cmd_active <= 1'b0;
		apb(1'b1, A_LIM, 32'h0);
		@(negedge pclk);
		chk(active_mode_allow, 1'b1);
		// without the hold any valid command ends the command at once
		@(posedge pclk);
		auto_anticollision_cmd_active <= 1'b1;
		pulse(P_CMD);
		within3(auto_anticollision_cmd_end, 1'b1);
		auto_anticollision_cmd_active <= 1'b0;
		$display("test anticollision done");
	endtask : t_acoll
	task automatic t_slot();
		@(posedge pclk);
		passive_mode <= 1'b1;
		rx_rate <= RATE_424;
		apb(1'b1, A_LIM, 32'h0000_0040);
		repeat (2) @(negedge pclk);
		chk(slot_half, 1'b1);
		apb(1'b1, A_LIM, 32'h0);
		repeat (2) @(negedge pclk);
		chk(slot_half, 1'b0);
		$display("test slot done");
	endtask : t_slot

	////////////////////////////////////////
	// reset for twelve cycles, then the scenarios in turn
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, card_mode, passive_mode} = '0;
		{rf_reset, halt_cmd_seen, auto_anticollision_cmd_active, select_done, polling_done} = '0;
		{valid_cmd, tx_req} = '0;
		pstrb = 4'hf;
		rx_rate = RATE_212;
		sync_detect_en = 1'b1;
		bit_sync_ok = 1'b1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_len();
		t_halt();
		t_resp();
		t_acoll();
		t_slot();
		end_of_test();
	end
endmodule : trx_top_tb
